/* sfc_map.svh */
// register offsets, reset values and timing constants of the serial format block
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
`define SFC_OFS_FMT      12'h000
`define SFC_OFS_HDR      12'h004
`define SFC_OFS_TERM     12'h008
`define SFC_OFS_CTRL     12'h00C
`define SFC_OFS_TXDATA   12'h010
`define SFC_OFS_RXDATA   12'h014
`define SFC_OFS_STATUS   12'h018
`define SFC_RST_FMT      16'h0000
`define SFC_RST_HDR      8'h02
`define SFC_RST_TERM     8'h03
`define SFC_CLK_HZ       50000000
`define SFC_BAUD_300     4'h3
`define SFC_BAUD_600     4'h4
`define SFC_BAUD_1200    4'h5
`define SFC_BAUD_2400    4'h6
`define SFC_BAUD_4800    4'h7
`define SFC_BAUD_9600    4'h8
`define SFC_BAUD_19200   4'h9
`define SFC_PAR_ODD      2'h1
`define SFC_PAR_EVEN     2'h3
`define SFC_FIFO_DEPTH   32
`endif

/* sfc_peer_model.sv */
// far-side serial unit: decodes frames seen on txd and sends frames on rxd
`timescale 1ns/10ps
module sfc_peer_model (
    input  wire logic        clk_sys,
    input  wire logic        txd,
    input  wire logic        tx_oe,
    input  wire logic [15:0] div,
    input  wire logic        len8,
    input  wire logic [1:0]  par,
    input  wire logic        stop2,
    output logic             rxd,
    output logic             rx_act
);
    logic [8:0] got_q[$];

    initial begin
        rxd = 1'b1;
        rx_act = 1'b0;
    end

    // samples mid-bit with the very format the device was given
    always begin : rx_loop
        logic [7:0] v;
        logic       bad;
        @(posedge clk_sys iff (tx_oe === 1'b1 && txd === 1'b0));
        repeat (div / 2) @(posedge clk_sys);
        bad = txd;
        v = 8'h00;
        for (int i = 0; i < (len8 ? 8 : 7); i++) begin
            repeat (div) @(posedge clk_sys);
            v[i] = txd;
        end
        if (par != 2'h0) begin
            repeat (div) @(posedge clk_sys);
            bad = bad | (((^v) ^ txd) != (par == 2'h1));
        end
        for (int i = 0; i < (stop2 ? 2 : 1); i++) begin
            repeat (div) @(posedge clk_sys);
            bad = bad | (txd !== 1'b1);
        end
        got_q.push_back({bad, v});
    end

    task automatic bit_out(input logic b);
        @(posedge clk_sys);
        rxd <= b;
        repeat (div - 1) @(posedge clk_sys);
    endtask : bit_out

    // line bias returns the pair to mark level after the frame
    task automatic send_char(input logic [7:0] c);
        logic [7:0] d;
        d = len8 ? c : {1'b0, c[6:0]};
        rx_act = 1'b1;
        bit_out(1'b0);
        for (int i = 0; i < (len8 ? 8 : 7); i++) bit_out(d[i]);
        if (par != 2'h0) bit_out((^d) ^ (par == 2'h1));
        if (stop2) bit_out(1'b1);
        // the device takes its frame at mid stop bit, so the line counts as free from there
        @(posedge clk_sys);
        rxd <= 1'b1;
        repeat (div / 2) @(posedge clk_sys);
        rx_act = 1'b0;
        repeat (div - 1 - div / 2) @(posedge clk_sys);
    endtask : send_char
endmodule : sfc_peer_model

/* sfc_pkg.sv */
// types of the serial format block
package sfc_pkg;
    typedef struct packed {
        logic       fmt4;
        logic       dedicated;
        logic       sum_en;
        logic       ctl2;
        logic       dtr_rx_only;
        logic       ctl1;
        logic       term_en;
        logic       hdr_en;
        logic [3:0] baud;
        logic       stop2;
        logic [1:0] par;
        logic       len8;
    } sfc_fmt_s;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} sfc_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} sfc_rx_e;
    typedef enum logic [2:0] {M_IDLE, M_HDR, M_DATA, M_SUM, M_TERM} sfc_msg_e;
endpackage : sfc_pkg

/* sfc_top.sv */
// serial frame format block: apb registers, transmit fifo, half-duplex framer
// Functional notes
// - format bits 2..1 pick no parity (00), odd (01) or even (11).
// - format bits 7..4 pick 300 to 19200 bit/s from codes 3 to 9.
// - in raw mode bit 8 sends the header character before the data.
// - in raw mode bit 9 sends the terminator character after the data.
// - bit 11 limits the control-line check to receiving only.
// - bit 13 appends an automatic sum-check code to each message.
// - bit 14 selects raw transfers or the dedicated protocol.
// - bit 15 marks protocol format 1 or 4; it is only read back, in the format register and status bit 8, and changes no framing.
// - the format is captured only when a transfer is started.
// - both partners use the same rate, parity and framing.
// - the port never transmits and receives at the same time.
`timescale 1ns/10ps
`include "sfc_map.svh"

module sfc_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         wr_valid,
    output logic              wr_ready,
    input  wire logic [W-1:0] wr_data,
    output logic              rd_valid,
    input  wire logic         rd_ready,
    output logic [W-1:0]      rd_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire push = wr_valid && wr_ready;
    wire pop  = rd_valid && rd_ready;
    assign wr_ready = cnt_q != (AW+1)'(D);
    assign rd_valid = cnt_q != '0;
    assign rd_data  = mem[rp_q];
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_q] <= wr_data;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= push ? AW'(wp_q + 1'b1) : wp_q;
            rp_q  <= pop ? AW'(rp_q + 1'b1) : rp_q;
            cnt_q <= (AW+1)'(cnt_q + push - pop);
        end
    end
endmodule : sfc_fifo

module sfc_top #(
    parameter int CLK_HZ = `SFC_CLK_HZ
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             txd,
    output logic             tx_oe,
    input  wire logic        rxd,
    input  wire logic        peer_rdy,
    output logic             local_rdy
);
    sfc_pkg::sfc_fmt_s fmt_w_q, fmt_q;
    sfc_pkg::sfc_tx_e  t_q, t_d;
    sfc_pkg::sfc_rx_e  r_q, r_d;
    sfc_pkg::sfc_msg_e m_q, m_d;
    logic [7:0]  hdr_q, term_q, sum_q, tsh_q, rsh_q, rxb_q, ch_d;
    logic [17:0] div_q, tcnt_q, rcnt_q;
    logic [2:0]  tix_q, rix_q;
    logic        run_q, ld_q, tst2_q, rst2_q, rxf_q, perr_q, ferr_q;
    logic        pready_q, pslverr_q, txd_q, oe_q, lrdy_q;
    logic [31:0] prdata_q;

    // bit period in clocks, rounded to nearest; unknown codes fall back to 9600
    function automatic logic [17:0] sfc_div(input logic [3:0] c);
        int r;
        unique case (c)
            `SFC_BAUD_300:   r = 300;
            `SFC_BAUD_600:   r = 600;
            `SFC_BAUD_1200:  r = 1200;
            `SFC_BAUD_2400:  r = 2400;
            `SFC_BAUD_4800:  r = 4800;
            `SFC_BAUD_19200: r = 19200;
            default:         r = 9600;
        endcase
        sfc_div = 18'((CLK_HZ + r / 2) / r);
    endfunction : sfc_div

    function automatic logic sfc_par(input logic [7:0] b, input logic [1:0] p);
        sfc_par = (p == `SFC_PAR_ODD) ? ~^b : ^b;
    endfunction : sfc_par

    // apb decode; access phase is two cycles, longer for a txdata write while the fifo is full
    wire acc     = psel && penable;
    wire hit_fmt = paddr == `SFC_OFS_FMT;
    wire hit_hdr = paddr == `SFC_OFS_HDR;
    wire hit_trm = paddr == `SFC_OFS_TERM;
    wire hit_ctl = paddr == `SFC_OFS_CTRL;
    wire hit_txd = paddr == `SFC_OFS_TXDATA;
    wire hit_rxd = paddr == `SFC_OFS_RXDATA;
    wire hit_sts = paddr == `SFC_OFS_STATUS;
    wire mapped  = hit_fmt | hit_hdr | hit_trm | hit_ctl | hit_txd | hit_rxd | hit_sts;
    wire fifo_wr_ready;
    wire fifo_rd_valid;
    wire [7:0] fifo_rd_data;
    wire stall   = pwrite && hit_txd && !fifo_wr_ready;
    wire done    = acc && pready_q;
    wire wr      = done && pwrite && !pslverr_q;
    wire rd_rx   = done && !pwrite && hit_rxd;
    wire start   = wr && hit_ctl && pwdata[0] && !run_q;
    wire [31:0] rdmux =
        hit_fmt ? {16'h0000, fmt_w_q} :
        hit_hdr ? {24'h000000, hdr_q} :
        hit_trm ? {24'h000000, term_q} :
        hit_ctl ? {31'h00000000, run_q} :
        hit_rxd ? {24'h000000, rxb_q} :
        hit_sts ? {22'h000000, r_q != sfc_pkg::RX_IDLE, fmt_q.fmt4, fmt_q.dedicated, ferr_q, perr_q,
                   rxf_q, !fifo_rd_valid, !fifo_wr_ready, oe_q, run_q} : 32'h00000000;

    // framing fields of the captured format
    wire [2:0]  nlast  = fmt_q.len8 ? 3'h7 : 3'h6;
    wire        par_en = fmt_q.par == `SFC_PAR_ODD || fmt_q.par == `SFC_PAR_EVEN;
    wire        ctl_en = fmt_q.ctl1 | fmt_q.ctl2;
    wire        tx_ok  = !ctl_en || fmt_q.dtr_rx_only || peer_rdy;
    wire        raw    = !fmt_q.dedicated;
    wire        ttick  = tcnt_q == div_q - 18'h00001;
    wire        rtick  = rcnt_q == div_q - 18'h00001;
    wire        rhalf  = rcnt_q == {1'b0, div_q[17:1]};
    wire        efree  = t_q == sfc_pkg::TX_IDLE && !ld_q;
    wire        pop    = efree && m_q == sfc_pkg::M_DATA && fifo_rd_valid;
    wire        rx_idl = r_q == sfc_pkg::RX_IDLE;
    wire [7:0]  rmask  = fmt_q.len8 ? rsh_q : {1'b0, rsh_q[7:1]};

    sfc_fifo #(.W(8), .D(`SFC_FIFO_DEPTH)) u_fifo (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wr_valid (wr && hit_txd),
        .wr_ready (fifo_wr_ready),
        .wr_data  (pwdata[7:0]),
        .rd_valid (fifo_rd_valid),
        .rd_ready (pop),
        .rd_data  (fifo_rd_data)
    );

    // message sequencer: header, fifo contents, sum, terminator
    always_comb begin
        m_d  = m_q;
        ch_d = 8'h00;
        unique case (m_q)
            sfc_pkg::M_IDLE:
                // a start bit already on the line wins, else both sides would start together
                if (run_q && fifo_rd_valid && tx_ok && rx_idl && efree && rxd) begin
                    m_d = (raw && fmt_q.hdr_en) ? sfc_pkg::M_HDR : sfc_pkg::M_DATA;
                end
            sfc_pkg::M_HDR: begin
                ch_d = hdr_q;
                m_d  = efree ? sfc_pkg::M_DATA : m_q;
            end
            sfc_pkg::M_DATA: begin
                ch_d = fifo_rd_data;
                if (efree && !fifo_rd_valid) begin
                    m_d = fmt_q.sum_en ? sfc_pkg::M_SUM :
                          (raw && fmt_q.term_en) ? sfc_pkg::M_TERM : sfc_pkg::M_IDLE;
                end
            end
            sfc_pkg::M_SUM: begin
                ch_d = sum_q;
                m_d  = !efree ? m_q : (raw && fmt_q.term_en) ? sfc_pkg::M_TERM : sfc_pkg::M_IDLE;
            end
            sfc_pkg::M_TERM: begin
                ch_d = term_q;
                m_d  = efree ? sfc_pkg::M_IDLE : m_q;
            end
        endcase
    end
    wire load = efree && (m_q == sfc_pkg::M_HDR || m_q == sfc_pkg::M_SUM || m_q == sfc_pkg::M_TERM || pop);

    // character transmitter
    always_comb begin
        t_d = t_q;
        unique case (t_q)
            sfc_pkg::TX_IDLE:  t_d = ld_q ? sfc_pkg::TX_START : t_q;
            sfc_pkg::TX_START: t_d = ttick ? sfc_pkg::TX_DATA : t_q;
            sfc_pkg::TX_DATA:
                if (ttick && tix_q == nlast) begin
                    t_d = par_en ? sfc_pkg::TX_PAR : sfc_pkg::TX_STOP;
                end
            sfc_pkg::TX_PAR:   t_d = ttick ? sfc_pkg::TX_STOP : t_q;
            sfc_pkg::TX_STOP:  t_d = (ttick && (tst2_q || !fmt_q.stop2)) ? sfc_pkg::TX_IDLE : t_q;
        endcase
    end
    wire [2:0] tix_d = (t_q == sfc_pkg::TX_DATA && ttick) ? 3'(tix_q + 1'b1) :
                       (t_q == sfc_pkg::TX_DATA) ? tix_q : 3'h0;
    wire [7:0] tbyte = fmt_q.len8 ? tsh_q : {1'b0, tsh_q[6:0]};
    wire txd_d = (t_d == sfc_pkg::TX_START) ? 1'b0 :
                 (t_d == sfc_pkg::TX_DATA) ? tsh_q[tix_d] :
                 (t_d == sfc_pkg::TX_PAR) ? sfc_par(tbyte, fmt_q.par) : 1'b1;

    // character receiver, idle whenever the sequencer owns the line
    always_comb begin
        r_d = r_q;
        unique case (r_q)
            sfc_pkg::RX_IDLE:
                r_d = (run_q && !rxd && m_q == sfc_pkg::M_IDLE && efree) ? sfc_pkg::RX_START : r_q;
            sfc_pkg::RX_START: r_d = !rhalf ? r_q : rxd ? sfc_pkg::RX_IDLE : sfc_pkg::RX_DATA;
            sfc_pkg::RX_DATA:
                if (rtick && rix_q == nlast) begin
                    r_d = par_en ? sfc_pkg::RX_PAR : sfc_pkg::RX_STOP;
                end
            sfc_pkg::RX_PAR:   r_d = rtick ? sfc_pkg::RX_STOP : r_q;
            sfc_pkg::RX_STOP:  r_d = (rtick && (rst2_q || !fmt_q.stop2)) ? sfc_pkg::RX_IDLE : r_q;
        endcase
    end
    wire rx_end  = r_q == sfc_pkg::RX_STOP && r_d == sfc_pkg::RX_IDLE;
    wire rx_pbit = r_q == sfc_pkg::RX_PAR && rtick;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fmt_w_q   <= `SFC_RST_FMT;
            fmt_q     <= `SFC_RST_FMT;
            hdr_q     <= `SFC_RST_HDR;
            term_q    <= `SFC_RST_TERM;
            run_q     <= 1'b0;
            div_q     <= 18'h00001;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= acc && !pready_q && !stall;
            pslverr_q <= acc && !pready_q && !mapped;
            prdata_q  <= (acc && !pready_q && !pwrite) ? rdmux : 32'h00000000;
            fmt_w_q   <= (wr && hit_fmt) ? pwdata[15:0] : fmt_w_q;
            hdr_q     <= (wr && hit_hdr) ? pwdata[7:0] : hdr_q;
            term_q    <= (wr && hit_trm) ? pwdata[7:0] : term_q;
            run_q     <= (wr && hit_ctl) ? pwdata[0] : run_q;
            fmt_q     <= start ? fmt_w_q : fmt_q;
            div_q     <= start ? sfc_div(fmt_w_q.baud) : div_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            m_q    <= sfc_pkg::M_IDLE;
            t_q    <= sfc_pkg::TX_IDLE;
            ld_q   <= 1'b0;
            tsh_q  <= 8'h00;
            sum_q  <= 8'h00;
            tcnt_q <= 18'h00000;
            tix_q  <= 3'h0;
            tst2_q <= 1'b0;
            txd_q  <= 1'b1;
            oe_q   <= 1'b0;
        end else begin
            m_q    <= m_d;
            t_q    <= t_d;
            ld_q   <= load;
            tsh_q  <= load ? ch_d : tsh_q;
            sum_q  <= (m_q == sfc_pkg::M_IDLE) ? 8'h00 : pop ? 8'(sum_q + fifo_rd_data) : sum_q;
            tcnt_q <= (t_d != t_q || ttick || t_q == sfc_pkg::TX_IDLE) ? 18'h00000 : 18'(tcnt_q + 1'b1);
            tix_q  <= tix_d;
            tst2_q <= (t_q == sfc_pkg::TX_STOP) ? (tst2_q | ttick) : 1'b0;
            txd_q  <= txd_d;
            oe_q   <= m_d != sfc_pkg::M_IDLE || t_d != sfc_pkg::TX_IDLE || load;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_q    <= sfc_pkg::RX_IDLE;
            rcnt_q <= 18'h00000;
            rix_q  <= 3'h0;
            rst2_q <= 1'b0;
            rsh_q  <= 8'h00;
            rxb_q  <= 8'h00;
            rxf_q  <= 1'b0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            lrdy_q <= 1'b0;
        end else begin
            r_q    <= r_d;
            rcnt_q <= (r_d != r_q || rtick || r_q == sfc_pkg::RX_IDLE) ? 18'h00000 : 18'(rcnt_q + 1'b1);
            rix_q  <= (r_q == sfc_pkg::RX_DATA) ? (rtick ? 3'(rix_q + 1'b1) : rix_q) : 3'h0;
            rst2_q <= (r_q == sfc_pkg::RX_STOP) ? (rst2_q | rtick) : 1'b0;
            rsh_q  <= (r_q == sfc_pkg::RX_DATA && rtick) ? {rxd, rsh_q[7:1]} : rsh_q;
            rxb_q  <= rx_end ? rmask : rxb_q;
            // a character finishing in the cycle its flag is read keeps the flag set
            rxf_q  <= rx_end | (rxf_q & !rd_rx);
            perr_q <= (rx_pbit && rxd != sfc_par(rmask, fmt_q.par)) | (perr_q & !rd_rx);
            ferr_q <= (r_q == sfc_pkg::RX_STOP && rtick && !rxd) | (ferr_q & !rd_rx);
            lrdy_q <= run_q && ctl_en && m_d == sfc_pkg::M_IDLE && t_d == sfc_pkg::TX_IDLE;
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign txd       = txd_q;
    assign tx_oe     = oe_q;
    assign local_rdy = lrdy_q;

    property p_fmt_hold;
        @(posedge clk_sys) disable iff (rst) !start |=> $stable(fmt_q);
    endproperty
    a_fmt_hold: assert property (p_fmt_hold) else $error("format changed without start");
    property p_div;
        @(posedge clk_sys) disable iff (rst) start |=> div_q == sfc_div(fmt_q.baud);
    endproperty
    a_div: assert property (p_div) else $error("bit period not taken from format");
    property p_half;
        @(posedge clk_sys) disable iff (rst) oe_q |-> r_q == sfc_pkg::RX_IDLE;
    endproperty
    a_half: assert property (p_half) else $error("receive while transmitting");
    property p_start_low;
        @(posedge clk_sys) disable iff (rst) $rose(t_q == sfc_pkg::TX_START) |-> !txd_q && oe_q;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");
    property p_stop_high;
        @(posedge clk_sys) disable iff (rst) t_q == sfc_pkg::TX_STOP |-> txd_q;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
    property p_nbits;
        @(posedge clk_sys) disable iff (rst) t_q == sfc_pkg::TX_DATA |-> tix_q <= nlast;
    endproperty
    a_nbits: assert property (p_nbits) else $error("too many data bits");
    property p_par;
        @(posedge clk_sys) disable iff (rst) t_q == sfc_pkg::TX_PAR |-> par_en && txd_q == sfc_par(tbyte, fmt_q.par);
    endproperty
    a_par: assert property (p_par) else $error("wrong parity bit");
    property p_hdr;
        @(posedge clk_sys) disable iff (rst) m_q == sfc_pkg::M_HDR && load |=> tsh_q == hdr_q && raw;
    endproperty
    a_hdr: assert property (p_hdr) else $error("header char wrong");
    property p_sum;
        @(posedge clk_sys) disable iff (rst) m_q == sfc_pkg::M_SUM |-> fmt_q.sum_en;
    endproperty
    a_sum: assert property (p_sum) else $error("sum sent while disabled");
    property p_term;
        @(posedge clk_sys) disable iff (rst) m_q == sfc_pkg::M_TERM && load |=> tsh_q == term_q && raw;
    endproperty
    a_term: assert property (p_term) else $error("terminator char wrong");
endmodule : sfc_top

/* sfc_top_tb.sv */
// self-checking bench of the serial format block against a far-side model
`timescale 1ns/10ps
`include "sfc_map.svh"
module sfc_top_tb;
    // lowered clock figure keeps the slow bit rates short
    localparam int CLK = 384000;
    logic        clk_sys, rst, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        pready, pslverr, txd, tx_oe, rxd, peer_rdy, local_rdy, rx_act, overlap, rde;
    logic [15:0] div;
    logic        len8, stop2;
    logic [1:0]  par;
    int          err_total, comparisons;
    int          rate[7] = '{300, 600, 1200, 2400, 4800, 9600, 19200};
    logic [1:0]  par_tab[3] = '{2'h0, `SFC_PAR_ODD, `SFC_PAR_EVEN};

    sfc_top #(.CLK_HZ(CLK)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .txd(txd), .tx_oe(tx_oe), .rxd(rxd), .peer_rdy(peer_rdy), .local_rdy(local_rdy)
    );
    sfc_peer_model peer_u (
        .clk_sys(clk_sys), .txd(txd), .tx_oe(tx_oe), .div(div), .len8(len8), .par(par),
        .stop2(stop2), .rxd(rxd), .rx_act(rx_act)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            overlap <= 1'b0;
        end else if (rx_act && tx_oe === 1'b1) begin
            overlap <= 1'b1;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 4000);
        rdv = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 4000) check(32'h0, 32'h1);
    endtask : apb

    task automatic push(input logic [7:0] b);
        apb(1'b1, `SFC_OFS_TXDATA, {24'h0, b});
    endtask : push

    // format only takes hold at the next start, so stop first
    task automatic set_fmt(input logic [15:0] f);
        apb(1'b1, `SFC_OFS_CTRL, 32'h0);
        // a start during the last stop bit would retime it, so let the line go idle first
        while (tx_oe !== 1'b0) @(posedge clk_sys);
        apb(1'b1, `SFC_OFS_FMT, {16'h0, f});
        len8 = f[0];
        par = f[2:1];
        stop2 = f[3];
        div = 16'(CLK / rate[f[7:4] - 4'h3]);
    endtask : set_fmt

    task automatic exp_ch(input logic [7:0] e);
        int n;
        n = 0;
        while (peer_u.got_q.size() == 0 && n < 40000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 40000) check(32'h0, 32'h1);
        else check({23'h0, peer_u.got_q.pop_front()}, {24'h0, len8 ? e : (e & 8'h7F)});
    endtask : exp_ch

    initial begin
        repeat (90000) @(posedge clk_sys);
        check(32'h0, 32'h1);
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        peer_rdy = 1'b0;
        err_total = 0;
        comparisons = 0;
        div = 16'h0014;
        len8 = 1'b1;
        par = 2'h0;
        stop2 = 1'b0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, `SFC_OFS_FMT, 32'h0);
        check(rdv, 32'h0);
        apb(1'b0, `SFC_OFS_HDR, 32'h0);
        check(rdv, 32'h2);
        apb(1'b0, `SFC_OFS_TERM, 32'h0);
        check(rdv, 32'h3);
        apb(1'b0, 12'hFFC, 32'h0);
        check({rdv[30:0], rde}, 32'h1);
        check({31'h0, local_rdy}, 32'h0);
        // every rate, length, parity and stop count; peer not ready is ignored
        for (int i = 0; i < 7; i++) begin
            logic [15:0] f;
            f = 16'h0C00;
            f[0] = i[0];
            f[3] = i[1];
            f[2:1] = par_tab[i % 3];
            f[7:4] = 4'(i + 3);
            set_fmt(f);
            push(8'hA5 ^ 8'(i));
            push(8'h3C);
            apb(1'b1, `SFC_OFS_CTRL, 32'h1);
            exp_ch(8'hA5 ^ 8'(i));
            exp_ch(8'h3C);
        end
        // header and terminator; a later format write must not take hold
        set_fmt(16'h0F91);
        apb(1'b1, `SFC_OFS_HDR, 32'h5B);
        apb(1'b1, `SFC_OFS_TERM, 32'h7E);
        push(8'h11);
        push(8'h22);
        apb(1'b1, `SFC_OFS_CTRL, 32'h1);
        apb(1'b1, `SFC_OFS_FMT, 32'hE000);
        exp_ch(8'h5B);
        exp_ch(8'h11);
        exp_ch(8'h22);
        exp_ch(8'h7E);
        push(8'h55);
        exp_ch(8'h5B);
        exp_ch(8'h55);
        exp_ch(8'h7E);
        apb(1'b0, `SFC_OFS_STATUS, 32'h0);
        check(rdv & 32'h180, 32'h0);
        // dedicated protocol, format 4, sum appended
        set_fmt(16'hE091);
        push(8'h11);
        push(8'h22);
        apb(1'b1, `SFC_OFS_CTRL, 32'h1);
        apb(1'b0, `SFC_OFS_STATUS, 32'h0);
        check(rdv & 32'h180, 32'h180);
        exp_ch(8'h11);
        exp_ch(8'h22);
        exp_ch(8'h33);
        // control-line check on both directions holds sending
        set_fmt(16'h0491);
        push(8'h66);
        apb(1'b1, `SFC_OFS_CTRL, 32'h1);
        repeat (300) @(posedge clk_sys);
        check({31'h0, tx_oe}, 32'h0);
        check({31'h0, local_rdy}, 32'h1);
        peer_rdy <= 1'b1;
        exp_ch(8'h66);
        // transmit queued during a reception must wait for it
        set_fmt(16'h0C91);
        apb(1'b1, `SFC_OFS_CTRL, 32'h1);
        fork
            peer_u.send_char(8'hC3);
            begin
                repeat (40) @(posedge clk_sys);
                push(8'h4D);
            end
        join
        repeat (40) @(posedge clk_sys);
        apb(1'b0, `SFC_OFS_STATUS, 32'h0);
        check(rdv & 32'h70, 32'h10);
        apb(1'b0, `SFC_OFS_RXDATA, 32'h0);
        check(rdv & 32'hFF, 32'hC3);
        exp_ch(8'h4D);
        check({31'h0, overlap}, 32'h0);
        // fifo filled until it refuses, then drained
        set_fmt(16'h0C91);
        for (int i = 0; i < `SFC_FIFO_DEPTH; i++) push(8'(i));
        apb(1'b0, `SFC_OFS_STATUS, 32'h0);
        check(rdv & 32'hC, 32'h4);
        apb(1'b1, `SFC_OFS_CTRL, 32'h1);
        push(8'hEE);
        for (int i = 0; i < `SFC_FIFO_DEPTH; i++) exp_ch(8'(i));
        exp_ch(8'hEE);
        apb(1'b0, `SFC_OFS_STATUS, 32'h0);
        check(rdv & 32'hC, 32'h8);
        end_of_test();
    end
endmodule : sfc_top_tb
